// ---- tsr_status_core.v ----
`timescale 1ns/1ps
`include "tsr_status_regs.vh"

module tsr_status_core (
  input  wire        ref_clk,         // 50 MHz system clock
  input  wire        srst,            // sync reset, active high
  // register command from header decoder
  input  wire        cmd_valid,       // register command strobe
  input  wire [3:0]  cmd_op,          // register command opcode
  output wire        cmd_ready,       // core idle, can take a command
  input  wire        arg_valid,       // data character strobe
  input  wire [7:0]  arg_char,        // data character
  input  wire        arg_end,         // end of data field
  // other messages handled elsewhere
  input  wire        other_valid,     // non-register message strobe
  input  wire        other_allowed,   // message marked available in test
  output reg         other_reject,    // pulse: message refused in test
  input  wire        hdr_err,         // pulse: header not recognised
  input  wire        syntax_err,      // pulse: syntax error elsewhere
  input  wire        data_err_in,     // pulse: data error elsewhere
  input  wire        range_err_in,    // pulse: out-of-range elsewhere
  // tester state
  input  wire        test_running,    // test in progress
  input  wire        judgment_shown,  // pass or fail being shown
  input  wire        test_stopped,    // test has stopped
  input  wire        fail_judg,       // fail judgment
  input  wire        pass_judg,       // pass judgment
  input  wire        voltage_output_active, // voltage output on
  input  wire        test_volt_on,    // test voltage output on
  input  wire        ready_state,     // ready state
  input  wire        fail_event,      // pulse: fail judgment made
  input  wire        fail_upper,      // cause: upper limit violated
  input  wire        fail_lower,      // cause: lower limit violated
  // settings
  input  wire        fixed_range,     // fixed range selected
  input  wire        upper_judg_on,   // upper judgment on
  input  wire        lower_judg_on,   // lower judgment on
  input  wire        timer_on,        // timer function on
  input  wire [13:0] test_time,       // test time, 0.1 s units
  input  wire [13:0] wait_time,       // wait time, 0.1 s units
  input  wire [18:0] lower_res,       // lower limit, 10 kohm units
  input  wire [18:0] upper_res,       // upper limit, 10 kohm units
  input  wire [11:0] test_voltage,    // test voltage, volts
  // response stream
  output wire        tx_valid,        // response character valid
  output reg  [7:0]  tx_char,         // response character
  input  wire        tx_ready,        // host side takes character
  output wire        invalid_setting_state // conflict present
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_ARG  = 3'b010;
  localparam [2:0] S_TX   = 3'b100;

  reg  [2:0] state_reg;
  reg  [3:0] op_reg;
  reg  [7:0] sre_reg;
  reg  [7:0] den_reg;
  reg  [7:0] esr_reg;
  reg  [7:0] dsr_reg;
  reg  [7:0] fail_reg;
  reg  [7:0] inv_reg;
  reg  [7:0] err_reg;
  reg  [7:0] tx_val_reg;
  reg  [1:0] tx_idx_reg;

  wire [7:0] p_value;
  wire       p_data_err;
  wire       p_range_err;

  // clear-type commands
  function is_clear;
    input [3:0] op;
    begin
      is_clear = (op == `TSR_OP_CLS) || (op == `TSR_OP_CLR);
    end
  endfunction

  // commands followed by a data field
  function is_write;
    input [3:0] op;
    begin
      is_write = (op == `TSR_OP_SRE_W) || (op == `TSR_OP_DEN_W);
    end
  endfunction

  wire busy = test_running | judgment_shown;
  wire take = (state_reg == S_IDLE) & cmd_valid;
  wire fin  = (state_reg == S_ARG) & arg_end;

  // commands marked unavailable during a test
  wire op_blocked = busy & (cmd_op == `TSR_OP_SRE_Q || cmd_op == `TSR_OP_DEN_W);
  wire op_known   = cmd_op <= `TSR_OP_CLR;
  wire reg_reject = take & op_known & op_blocked;
  wire oth_reject = other_valid & busy & ~other_allowed;
  wire any_reject = reg_reject | oth_reject;
  wire bad_hdr    = hdr_err | (take & ~op_known);

  wire arg_derr = fin & p_data_err;
  wire arg_rerr = fin & p_range_err;
  wire arg_ok   = fin & ~p_data_err & ~p_range_err;

  wire do_clr   = take & ~op_blocked & is_clear(cmd_op);
  wire do_query = take & op_known & ~op_blocked & ~is_clear(cmd_op) & ~is_write(cmd_op);
  wire rd_esr = take & (cmd_op == `TSR_OP_ESR_Q);
  wire rd_err = take & (cmd_op == `TSR_OP_ERR_Q);

  // live conflict conditions
  wire [22:0] curr_lim = lower_res * `TSR_CURR_K;
  wire [7:0]  inv_live;
  assign inv_live[7:5]            = 3'b000;
  assign inv_live[`TSR_INV_FIX]   = fixed_range & upper_judg_on;
  assign inv_live[`TSR_INV_WAIT]  = timer_on & (wait_time >= test_time);
  assign inv_live[`TSR_INV_ORDER] = upper_judg_on & lower_judg_on &
                                    (lower_res >= upper_res);
  assign inv_live[`TSR_INV_CURR]  = {11'h000, test_voltage} > curr_lim;
  assign inv_live[0]              = 1'b0;
  assign invalid_setting_state    = |inv_live;

  wire [7:0] dsr_live;
  assign dsr_live[7]              = 1'b0;
  assign dsr_live[`TSR_DSR_STOP]  = test_stopped;
  assign dsr_live[`TSR_DSR_FAIL]  = fail_judg;
  assign dsr_live[`TSR_DSR_PASS]  = pass_judg;
  assign dsr_live[`TSR_DSR_VOUT]  = voltage_output_active;
  assign dsr_live[`TSR_DSR_TEST]  = test_volt_on;
  assign dsr_live[`TSR_DSR_INV]   = invalid_setting_state;
  assign dsr_live[`TSR_DSR_READY] = ready_state;

  wire [7:0] esr_set;
  assign esr_set[`TSR_ESR_CME] = syntax_err | data_err_in | range_err_in |
                                 bad_hdr | arg_derr | arg_rerr;
  assign esr_set[`TSR_ESR_EXE] = any_reject;
  assign esr_set[7:6]          = 2'b00;
  assign esr_set[3:0]          = 4'h0;

  wire [7:0] err_set;
  assign err_set[`TSR_ERR_INVMSG] = any_reject;
  assign err_set[`TSR_ERR_RANGE]  = range_err_in | arg_rerr;
  assign err_set[`TSR_ERR_DATA]   = data_err_in | arg_derr;
  assign err_set[`TSR_ERR_HDR]    = bad_hdr;
  assign err_set[7:4]             = 4'h0;

  wire [7:0] fail_set;
  assign fail_set[7:3]             = 5'h00;
  assign fail_set[`TSR_FAIL_UPPER] = fail_event & fail_upper;
  assign fail_set[`TSR_FAIL_LOWER] = fail_event & fail_lower;
  assign fail_set[0]               = 1'b0;

  // status summary byte, derived from the registers below
  wire [7:0] stb_base;
  assign stb_base[`TSR_STB_ESB] = |esr_reg;
  assign stb_base[`TSR_STB_DEV] = |dsr_reg;
  assign stb_base[7:6]          = 2'b00;
  assign stb_base[3:0]          = 4'h0;
  wire       mss = |(stb_base & sre_reg & `TSR_STB_USED);
  wire [7:0] stb;
  assign stb[7]            = 1'b0;
  assign stb[`TSR_STB_MSS] = mss;
  assign stb[5:0]          = stb_base[5:0];

  reg [7:0] q_val;
  always @* begin
    case (cmd_op)
      `TSR_OP_ESR_Q:  q_val = esr_reg;
      `TSR_OP_SRE_Q:  q_val = sre_reg;
      `TSR_OP_STB_Q:  q_val = stb;
      `TSR_OP_DEN_Q:  q_val = den_reg;
      `TSR_OP_DSR_Q:  q_val = dsr_reg;
      `TSR_OP_ERR_Q:  q_val = err_reg;
      `TSR_OP_FAIL_Q: q_val = fail_reg;
      `TSR_OP_INV_Q:  q_val = inv_reg;
      default:        q_val = `TSR_RST_BYTE;
    endcase
  end

  // decimal digit character of v: 0 hundreds, 1 tens, 2 ones, 3 terminator
  function [7:0] dec_char;
    input [7:0] v;
    input [1:0] idx;
    reg   [7:0] d;
    begin
      d = 8'h00;
      case (idx)
        2'd0:    d = v / 8'd100;
        2'd1:    d = (v / 8'd10) % 8'd10;
        2'd2:    d = v % 8'd10;
        default: d = 8'h00;
      endcase
      dec_char = (idx == 2'd3) ? `TSR_CH_LF : `TSR_CH_ZERO + d;
    end
  endfunction

  wire [1:0] first_idx = (q_val >= 8'd100) ? 2'd0 : (q_val >= 8'd10) ? 2'd1 : 2'd2;

  tsr_num_parse u_parse (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .start     (take),
    .chr_valid (arg_valid & (state_reg == S_ARG)),
    .chr       (arg_char),
    .value     (p_value),
    .data_err  (p_data_err),
    .range_err (p_range_err)
  );

  // flags: hardware set wins over a clear in the same cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      sre_reg  <= `TSR_RST_BYTE;
      den_reg  <= `TSR_RST_BYTE;
      esr_reg  <= `TSR_RST_BYTE;
      dsr_reg  <= `TSR_RST_BYTE;
      fail_reg <= `TSR_RST_BYTE;
      inv_reg  <= `TSR_RST_BYTE;
      err_reg  <= `TSR_RST_BYTE;
    end else begin
      esr_reg  <= ((do_clr | rd_esr) ? 8'h00 : esr_reg) | esr_set;
      err_reg  <= ((do_clr | rd_err) ? 8'h00 : err_reg) | err_set;
      dsr_reg  <= (do_clr ? 8'h00 : dsr_reg) | (dsr_live & `TSR_DSR_USED);
      fail_reg <= (do_clr ? 8'h00 : fail_reg) | fail_set;
      inv_reg  <= (do_clr ? 8'h00 : inv_reg) | inv_live;
      if (take && cmd_op == `TSR_OP_CLR) begin
        sre_reg <= `TSR_RST_BYTE;
        den_reg <= `TSR_RST_BYTE;
      end else if (arg_ok && op_reg == `TSR_OP_SRE_W) begin
        sre_reg <= p_value & `TSR_STB_USED;
      end else if (arg_ok && op_reg == `TSR_OP_DEN_W) begin
        den_reg <= p_value & `TSR_DSR_USED;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      state_reg    <= S_IDLE;
      op_reg       <= 4'h0;
      tx_val_reg   <= 8'h00;
      tx_idx_reg   <= 2'd0;
      tx_char      <= 8'h00;
      other_reject <= 1'b0;
    end else begin
      other_reject <= oth_reject;
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            op_reg <= cmd_op;
            if (do_query) begin
              tx_val_reg <= q_val;
              tx_idx_reg <= first_idx;
              tx_char    <= dec_char(q_val, first_idx);
              state_reg  <= S_TX;
            end else if (!op_blocked && is_write(cmd_op)) begin
              state_reg <= S_ARG;
            end
          end
        end
        S_ARG: begin
          if (arg_end)
            state_reg <= S_IDLE;
        end
        S_TX: begin
          if (tx_ready) begin
            if (tx_idx_reg == 2'd3) begin
              state_reg <= S_IDLE;
            end else begin
              tx_idx_reg <= tx_idx_reg + 2'd1;
              tx_char    <= dec_char(tx_val_reg, tx_idx_reg + 2'd1);
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign cmd_ready = (state_reg == S_IDLE);
  assign tx_valid  = (state_reg == S_TX);

endmodule // tsr_status_core

// ---- tsr_status_regs.vh ----
`ifndef TSR_STATUS_REGS_VH
`define TSR_STATUS_REGS_VH

// command opcodes presented by the header decoder
`define TSR_OP_CLS      4'h0
`define TSR_OP_ESR_Q    4'h1
`define TSR_OP_SRE_W    4'h2
`define TSR_OP_SRE_Q    4'h3
`define TSR_OP_STB_Q    4'h4
`define TSR_OP_DEN_W    4'h5
`define TSR_OP_DEN_Q    4'h6
`define TSR_OP_DSR_Q    4'h7
`define TSR_OP_ERR_Q    4'h8
`define TSR_OP_FAIL_Q   4'h9
`define TSR_OP_INV_Q    4'hA
`define TSR_OP_CLR      4'hB

// status summary byte
`define TSR_STB_MSS     6
`define TSR_STB_ESB     5
`define TSR_STB_DEV     4
`define TSR_STB_USED    8'h70
// event status
`define TSR_ESR_CME     5
`define TSR_ESR_EXE     4
`define TSR_ESR_USED    8'h30
// device status
`define TSR_DSR_STOP    6
`define TSR_DSR_FAIL    5
`define TSR_DSR_PASS    4
`define TSR_DSR_VOUT    3
`define TSR_DSR_TEST    2
`define TSR_DSR_INV     1
`define TSR_DSR_READY   0
`define TSR_DSR_USED    8'h7F
// fail flags
`define TSR_FAIL_UPPER  2
`define TSR_FAIL_LOWER  1
// setting conflict flags
`define TSR_INV_FIX     4
`define TSR_INV_WAIT    3
`define TSR_INV_ORDER   2
`define TSR_INV_CURR    1
// message error flags
`define TSR_ERR_INVMSG  3
`define TSR_ERR_RANGE   2
`define TSR_ERR_DATA    1
`define TSR_ERR_HDR     0

// reset values
`define TSR_RST_BYTE    8'h00

// current limit: volts > TSR_CURR_K * (resistance in 10 kohm units) means above 1.1 mA
`define TSR_CURR_K      23'h00_000B

// ascii characters and largest data value
`define TSR_CH_HASH     8'h23
`define TSR_CH_H_UP     8'h48
`define TSR_CH_H_LO     8'h68
`define TSR_CH_SPACE    8'h20
`define TSR_CH_ZERO     8'h30
`define TSR_CH_LF       8'h0A
`define TSR_MAX_DATA    12'h0_0FF

`endif

// ---- tsr_num_parse.v ----
`timescale 1ns/1ps
`include "tsr_status_regs.vh"

module tsr_num_parse (
  input  wire       ref_clk,    // system clock
  input  wire       srst,       // sync reset, active high
  input  wire       start,      // restart parsing
  input  wire       chr_valid,  // data character strobe
  input  wire [7:0] chr,        // data character
  output wire [7:0] value,      // parsed value
  output wire       data_err,   // malformed data
  output wire       range_err   // value above 255
);

  reg  [7:0]  acc_reg;
  reg  [1:0]  pfx_reg;
  reg         dig_reg;
  reg         bad_reg;
  reg         over_reg;
  reg  [4:0]  dval;
  reg  [11:0] acc_next;

  // bit 4 set means not a digit of the selected base
  function [4:0] digit_of;
    input [7:0] c;
    input       hex;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        digit_of = {1'b0, c[3:0]};
      else if (hex && ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)))
        digit_of = {1'b0, c[3:0] + 4'h9};
      else
        digit_of = 5'h10;
    end
  endfunction

  always @* begin
    dval     = digit_of(chr, pfx_reg[1]);
    acc_next = pfx_reg[1] ? {acc_reg, 4'h0} + {8'h00, dval[3:0]}
                          : {4'h0, acc_reg} * 12'h00A + {8'h00, dval[3:0]};
  end

  always @(posedge ref_clk) begin
    if (srst || start) begin
      acc_reg  <= 8'h00;
      pfx_reg  <= 2'b00;
      dig_reg  <= 1'b0;
      bad_reg  <= 1'b0;
      over_reg <= 1'b0;
    end else if (chr_valid) begin
      if (chr == `TSR_CH_SPACE && !dig_reg && pfx_reg != 2'b01) begin
      end else if (chr == `TSR_CH_HASH && !dig_reg && pfx_reg == 2'b00) begin
        pfx_reg <= 2'b01;
      end else if (pfx_reg == 2'b01) begin
        if (chr == `TSR_CH_H_UP || chr == `TSR_CH_H_LO)
          pfx_reg <= 2'b10;
        else
          bad_reg <= 1'b1;
      end else if (dval[4]) begin
        bad_reg <= 1'b1;
      end else begin
        dig_reg <= 1'b1;
        if (over_reg || acc_next > `TSR_MAX_DATA)
          over_reg <= 1'b1;
        else
          acc_reg <= acc_next[7:0];
      end
    end
  end

  assign value     = acc_reg;
  assign data_err  = bad_reg | ~dig_reg;
  assign range_err = over_reg & ~data_err;

endmodule // tsr_num_parse

// ---- tsr_host_model.sv ----
`timescale 1ns/1ps
module tsr_host_model (
  input  wire        ref_clk,   // system clock
  input  wire        srst,      // sync reset, active high
  input  wire        slow,      // stall on every other cycle
  input  wire        tx_valid,  // response character valid
  input  wire [7:0]  tx_char,   // response character
  output reg         tx_ready,  // host takes character
  output reg         resp_done, // pulse: whole answer taken
  output reg  [15:0] resp_val   // decoded decimal answer
);
  reg [15:0] acc_reg;
  always @(posedge ref_clk) begin
    resp_done <= ~srst & tx_valid & tx_ready & (tx_char == 8'h0A);
    if (srst) begin
      acc_reg  <= 16'h0000;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    if (!srst && tx_valid && tx_ready) begin
      if (tx_char == 8'h0A) begin // line feed ends the answer
        resp_val  <= acc_reg;
        acc_reg   <= 16'h0000;
      end else begin
        acc_reg <= acc_reg * 16'h000A + {8'h00, tx_char} - 16'h0030; // decimal digit
      end
    end
  end
endmodule // tsr_host_model

// ---- tsr_status_core_assertions.sv ----
`timescale 1ns/1ps
module tsr_status_core_assertions (
  input wire        ref_clk,               // system clock
  input wire        srst,                  // sync reset
  input wire        cmd_valid,             // command strobe
  input wire [3:0]  cmd_op,                // command opcode
  input wire        cmd_ready,             // core idle
  input wire        other_valid,           // other message strobe
  input wire        other_allowed,         // available in test
  input wire        other_reject,          // refusal pulse
  input wire        test_running,          // test in progress
  input wire        judgment_shown,        // judgment shown
  input wire        fixed_range,           // fixed range
  input wire        upper_judg_on,         // upper judgment on
  input wire        lower_judg_on,         // lower judgment on
  input wire        timer_on,              // timer on
  input wire [13:0] test_time,             // test time
  input wire [13:0] wait_time,             // wait time
  input wire [18:0] lower_res,             // lower limit
  input wire [18:0] upper_res,             // upper limit
  input wire [11:0] test_voltage,          // test voltage
  input wire        tx_valid,              // response valid
  input wire [7:0]  tx_char,               // response char
  input wire        tx_ready,              // host ready
  input wire        invalid_setting_state  // conflict present
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire        busy = test_running || judgment_shown;
  wire [23:0] curr_lim = {5'h00, lower_res} * 24'h00_000B;
  wire        c_fix = fixed_range && upper_judg_on;
  wire        c_wait = timer_on && (wait_time >= test_time);
  wire        c_ord = upper_judg_on && lower_judg_on && (lower_res >= upper_res);
  wire        c_cur = {12'h000, test_voltage} > curr_lim;
  sequence s_query;
    cmd_valid && cmd_ready && (cmd_op inside {4'h1, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA});
  endsequence
  sequence s_refused;
    cmd_valid && cmd_ready && busy && (cmd_op == 4'h3 || cmd_op == 4'h5);
  endsequence
  AST_QUERY_ANSWER: assert property (s_query |=> tx_valid && !cmd_ready)
    else $error("query not answered next cycle");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("response char not held");
  AST_TX_DIGIT: assert property (tx_valid |-> tx_char inside {[8'h30:8'h39], 8'h0A})
    else $error("response char not decimal");
  AST_BUSY_REFUSE: assert property (s_refused |=> cmd_ready && !tx_valid)
    else $error("blocked command accepted in test");
  AST_REJECT: assert property (other_valid && busy && !other_allowed |=> other_reject)
    else $error("message not refused in test");
  AST_REJ_CAUSE: assert property (other_reject |-> $past(other_valid))
    else $error("refusal without message");
  AST_INV_FIX: assert property (c_fix |-> invalid_setting_state)
    else $error("fixed range conflict missed");
  AST_INV_WAIT: assert property (c_wait |-> invalid_setting_state)
    else $error("wait time conflict missed");
  AST_INV_ORDER: assert property (c_ord |-> invalid_setting_state)
    else $error("limit order conflict missed");
  AST_INV_CURR: assert property (c_cur |-> invalid_setting_state)
    else $error("current conflict missed");
  AST_INV_NONE: assert property (!(c_fix || c_wait || c_ord || c_cur) |-> !invalid_setting_state)
    else $error("conflict shown without cause");
endmodule // tsr_status_core_assertions

bind tsr_status_core tsr_status_core_assertions u_chk (
  .ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_ready(cmd_ready), .other_valid(other_valid), .other_allowed(other_allowed),
  .other_reject(other_reject), .test_running(test_running), .judgment_shown(judgment_shown),
  .fixed_range(fixed_range), .upper_judg_on(upper_judg_on), .lower_judg_on(lower_judg_on),
  .timer_on(timer_on), .test_time(test_time), .wait_time(wait_time), .lower_res(lower_res),
  .upper_res(upper_res), .test_voltage(test_voltage), .tx_valid(tx_valid), .tx_char(tx_char),
  .tx_ready(tx_ready), .invalid_setting_state(invalid_setting_state));

// ---- tsr_status_core_test.sv ----
`timescale 1ns/1ps
`include "tsr_status_regs.vh"
module tsr_status_core_test;
  reg         ref_clk = 1'b0;
  reg         srst = 1'b1;
  reg         cmd_valid, arg_valid, arg_end, other_valid, other_allowed, slow;
  reg         test_running, judgment_shown, fail_event, fail_upper, fail_lower;
  reg  [3:0]  cmd_op, pe, cf;
  reg  [5:0]  st;
  reg  [7:0]  arg_char;
  reg  [13:0] test_time, wait_time;
  reg  [18:0] lower_res, upper_res;
  reg  [11:0] test_voltage;
  wire        cmd_ready, other_reject, tx_valid, tx_ready, resp_done, inv_state;
  wire [7:0]  tx_char;
  wire [15:0] resp_val;
  integer     mismatches, num_checks, i;
  always #10 ref_clk = ~ref_clk;
  tsr_status_core dut (
    .ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ready(cmd_ready), .arg_valid(arg_valid), .arg_char(arg_char), .arg_end(arg_end),
    .other_valid(other_valid), .other_allowed(other_allowed), .other_reject(other_reject),
    .hdr_err(pe[0]), .syntax_err(pe[1]), .data_err_in(pe[2]), .range_err_in(pe[3]),
    .test_running(test_running), .judgment_shown(judgment_shown), .test_stopped(st[5]),
    .fail_judg(st[4]), .pass_judg(st[3]), .voltage_output_active(st[2]),
    .test_volt_on(st[1]), .ready_state(st[0]), .fail_event(fail_event),
    .fail_upper(fail_upper), .fail_lower(fail_lower), .fixed_range(cf[3]),
    .upper_judg_on(cf[2]), .lower_judg_on(cf[1]), .timer_on(cf[0]), .test_time(test_time),
    .wait_time(wait_time), .lower_res(lower_res), .upper_res(upper_res),
    .test_voltage(test_voltage), .tx_valid(tx_valid), .tx_char(tx_char),
    .tx_ready(tx_ready), .invalid_setting_state(inv_state));
  tsr_host_model host (.ref_clk(ref_clk), .srst(srst), .slow(slow), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_ready(tx_ready), .resp_done(resp_done), .resp_val(resp_val));
  task end_sim;
    begin
      if (mismatches == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %0d seen %0d", what, exp, got);
      end
    end
  endtask
  task cmd(input [3:0] op);
    integer n;
    begin
      n = 0;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 200) begin
        n = n + 1;
        @(negedge ref_clk);
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
    end
  endtask
  task wr(input [3:0] op, input string s);
    integer k;
    begin
      cmd(op);
      for (k = 0; k < s.len(); k = k + 1) begin
        arg_valid <= 1'b1;
        arg_char  <= s[k];
        @(posedge ref_clk);
      end
      arg_valid <= 1'b0;
      arg_end   <= 1'b1;
      @(posedge ref_clk);
      arg_end <= 1'b0;
    end
  endtask
  task qry(input [3:0] op, input [15:0] exp, input string what);
    integer n;
    begin
      cmd(op);
      n = 0;
      while (resp_done !== 1'b1 && n < 200) begin
        n = n + 1;
        @(negedge ref_clk);
      end
      chk("answer", 16'h0001, {15'h0000, n < 200});
      chk(what, exp, resp_val);
      @(posedge ref_clk);
    end
  endtask
  task other(input allowed, input [15:0] exp);
    begin
      @(posedge ref_clk);
      other_valid   <= 1'b1;
      other_allowed <= allowed;
      @(posedge ref_clk);
      other_valid <= 1'b0;
      @(negedge ref_clk);
      chk("reject", exp, {15'h0000, other_reject});
      @(posedge ref_clk);
    end
  endtask
  task conf(input [3:0] c, input [13:0] w, input [18:0] lr, input [11:0] v, input [15:0] e);
    begin
      @(posedge ref_clk);
      cf           <= c;
      wait_time    <= w;
      lower_res    <= lr;
      test_voltage <= v;
      cmd(`TSR_OP_CLS);
      qry(`TSR_OP_INV_Q, e, "invalid");
      chk("conflict", {15'h0000, e != 16'h0000}, {15'h0000, inv_state});
    end
  endtask
  task fl(input up, input [15:0] e);
    begin
      @(posedge ref_clk);
      fail_event <= 1'b1;
      fail_upper <= up;
      fail_lower <= !up;
      @(posedge ref_clk);
      fail_event <= 1'b0;
      qry(`TSR_OP_FAIL_Q, e, "fail");
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    end_sim;
  end
  initial begin
    {cmd_valid, arg_valid, arg_end, other_valid, other_allowed, slow} = 6'h00;
    {test_running, judgment_shown, fail_event, fail_upper, fail_lower} = 5'h00;
    {cmd_op, pe, cf, arg_char} = 20'h0_0000;
    st = 6'h01;
    test_time = 14'h0014;
    wait_time = 14'h0005;
    lower_res = 19'h0_0064;
    upper_res = 19'h0_03E8;
    test_voltage = 12'h1F4;
    mismatches = 0;
    num_checks = 0;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    qry(`TSR_OP_SRE_Q, 16'h0000, "sre");
    qry(`TSR_OP_DEN_Q, 16'h0000, "den");
    qry(`TSR_OP_DSR_Q, 16'h0001, "dsr");
    qry(`TSR_OP_STB_Q, 16'h0010, "stb");
    slow <= 1'b1;
    wr(`TSR_OP_SRE_W, "48");
    qry(`TSR_OP_SRE_Q, 16'h0030, "sre");
    wr(`TSR_OP_SRE_W, " #H7F");
    qry(`TSR_OP_SRE_Q, 16'h0070, "sre");
    qry(`TSR_OP_STB_Q, 16'h0050, "stb");
    wr(`TSR_OP_DEN_W, "#hff");
    qry(`TSR_OP_DEN_Q, 16'h007F, "den");
    cmd(4'hC);
    qry(`TSR_OP_ERR_Q, 16'h0001, "err");
    qry(`TSR_OP_ERR_Q, 16'h0000, "err");
    qry(`TSR_OP_STB_Q, 16'h0070, "stb");
    qry(`TSR_OP_ESR_Q, 16'h0020, "esr");
    qry(`TSR_OP_ESR_Q, 16'h0000, "esr");
    wr(`TSR_OP_SRE_W, "4G");
    wr(`TSR_OP_SRE_W, "256");
    qry(`TSR_OP_ERR_Q, 16'h0006, "err");
    qry(`TSR_OP_SRE_Q, 16'h0070, "sre");
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge ref_clk);
      pe <= 4'h1 << i;
      @(posedge ref_clk);
      pe <= 4'h0;
      qry(`TSR_OP_ESR_Q, 16'h0020, "esr");
    end
    cmd(`TSR_OP_CLS);
    test_running <= 1'b1;
    other(1'b0, 16'h0001);
    other(1'b1, 16'h0000);
    wr(`TSR_OP_DEN_W, "1");
    qry(`TSR_OP_DEN_Q, 16'h007F, "den");
    qry(`TSR_OP_ERR_Q, 16'h0008, "err");
    qry(`TSR_OP_ESR_Q, 16'h0010, "esr");
    test_running   <= 1'b0;
    judgment_shown <= 1'b1;
    other(1'b0, 16'h0001);
    judgment_shown <= 1'b0;
    st <= 6'h3F;
    conf(4'hC, 14'h0005, 19'h0_0064, 12'h1F4, 16'h0010);
    qry(`TSR_OP_DSR_Q, 16'h007F, "dsr");
    conf(4'h1, 14'h0014, 19'h0_0064, 12'h1F4, 16'h0008);
    conf(4'h1, 14'h0013, 19'h0_0064, 12'h1F4, 16'h0000);
    conf(4'h6, 14'h0005, 19'h0_03E8, 12'h1F4, 16'h0004);
    conf(4'h0, 14'h0005, 19'h0_000A, 12'h06F, 16'h0002);
    conf(4'h0, 14'h0005, 19'h0_000A, 12'h06E, 16'h0000);
    st <= 6'h01;
    fl(1'b1, 16'h0004);
    cmd(`TSR_OP_CLS);
    fl(1'b0, 16'h0002);
    cmd(4'hD);
    cmd(`TSR_OP_CLS);
    qry(`TSR_OP_ESR_Q, 16'h0000, "esr");
    qry(`TSR_OP_ERR_Q, 16'h0000, "err");
    qry(`TSR_OP_FAIL_Q, 16'h0000, "fail");
    qry(`TSR_OP_DSR_Q, 16'h0001, "dsr");
    cmd(`TSR_OP_CLR);
    qry(`TSR_OP_SRE_Q, 16'h0000, "sre");
    qry(`TSR_OP_DEN_Q, 16'h0000, "den");
    end_sim;
  end
endmodule // tsr_status_core_test
